//--- hw/stage_ctrl_defines.svh
// Notes on behaviour
// - two interrupt requests per instance
// - end-of-cycle irq on rb compare match
// - capture irq on retrigger, capture, sync error
// - vector order instance 2 first, capture first
// - out3 takes b, or a when set
// - out2 takes a, or b when set
// - ramp modes: sync on chosen output edge
// - centered: ra match down/up, else none
// - instance 2 bit3 drives out3 pin
// - bit2 drives output 1 pin from b
// - instance 2 bit1 drives out2 pin
// - bit0 drives output 0 pin from a
// - sa ra sb twelve bits, write only
// - rb sixteen bits, write only, zero reset
// - instances 0,1 same; 2 adds extras
// - shared temp high byte for compare writes
// - rb upper nibble is fine resolution
`ifndef STAGE_CTRL_DEFINES_SVH
`define STAGE_CTRL_DEFINES_SVH
`define CFG_BASE_ADDR 8'h00
`define CMP_BASE_ADDR 8'h20
`define IRQ_STATUS_ADDR 8'h80
`define IRQ_MASK_ADDR 8'h84
`define VECTOR_ADDR 8'h88
`define CMP_SA_LO 3'h0
`define CMP_SA_HI 3'h1
`define CMP_RA_LO 3'h2
`define CMP_RA_HI 3'h3
`define CMP_SB_LO 3'h4
`define CMP_SB_HI 3'h5
`define CMP_RB_LO 3'h6
`define CMP_RB_HI 3'h7
`define POS_OUT3_SEL 7
`define POS_OUT2_SEL 6
`define POS_SYNC_HI 5
`define POS_SYNC_LO 4
`define POS_OUT3_EN 3
`define POS_PART_B_EN 2
`define POS_OUT2_EN 1
`define POS_PART_A_EN 0
`define CFG_RESET 8'h00
`define CMP_RESET 16'h0000
`define FIRST_VECTOR 4'h2
`define FIRST_PROG_ADDR 16'h0001
`endif

//--- hw/stage_ctrl_pkg.sv
package stage_ctrl_pkg;
  typedef enum logic [1:0] {
    SYNC_A_LEAD = 2'h0,
    SYNC_A_TRAIL = 2'h1,
    SYNC_B_LEAD = 2'h2,
    SYNC_B_TRAIL = 2'h3
  } sync_sel_e;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_WRESP = 3'h2,
    BUS_RRESP = 3'h4
  } bus_state_e;
  typedef logic [7:0] byte_t;
endpackage : stage_ctrl_pkg

//--- hw/stage_unit.sv
`timescale 1ns/100ps
`include "stage_ctrl_defines.svh"
module stage_unit #(
  parameter bit HAS_EXTRA = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic cfg_we_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic cmp_we_in,
  input wire logic [2:0] cmp_sel_in,
  input wire logic [7:0] temp_high_in,
  input wire logic [7:0] cmp_wdata_in,
  input wire logic centered_in,
  input wire logic count_down_in,
  input wire logic [11:0] count_in,
  input wire logic wave_a_in,
  input wire logic wave_b_in,
  input wire logic fault_a_in,
  input wire logic fault_b_in,
  input wire logic sa_match_in,
  input wire logic rb_match_in,
  output logic [7:0] cfg_out,
  output logic [11:0] cmp_set_a_out,
  output logic [11:0] cmp_reset_a_out,
  output logic [11:0] cmp_set_b_out,
  output logic [15:0] cmp_reset_b_out,
  output logic adc_sync_out,
  output logic [3:0] pin_level_out,
  output logic [3:0] pin_oe_out
);
  typedef struct packed {
    logic [7:0] cfg;
    logic [11:0] sa;
    logic [11:0] ra;
    logic [11:0] sb;
    logic [15:0] rb;
    logic sync;
    logic [3:0] lvl;
    logic [3:0] oe;
  } unit_s;
  unit_s st_q, st_d;
  logic ra_match, sb_match;
  always_comb begin
    ra_match = (count_in == st_q.ra);
    sb_match = (count_in == st_q.sb);
  end
  always_comb begin
    st_d = st_q;
    if (cfg_we_in) begin
      st_d.cfg = cfg_wdata_in;
      if (!HAS_EXTRA) begin
        st_d.cfg[`POS_OUT3_SEL] = cfg_wdata_in[`POS_OUT3_SEL];
      end
    end
    if (cmp_we_in) begin
      // low byte write commits shared temp high byte together
      case (cmp_sel_in)
        `CMP_SA_LO: st_d.sa = {temp_high_in[3:0], cmp_wdata_in};
        `CMP_RA_LO: st_d.ra = {temp_high_in[3:0], cmp_wdata_in};
        `CMP_SB_LO: st_d.sb = {temp_high_in[3:0], cmp_wdata_in};
        `CMP_RB_LO: st_d.rb = {temp_high_in, cmp_wdata_in};
        default: st_d.sa = st_q.sa;
      endcase
    end
    st_d.sync = 1'b0;
    if (centered_in) begin
      case (stage_ctrl_pkg::sync_sel_e'(st_q.cfg[`POS_SYNC_HI:`POS_SYNC_LO]))
        stage_ctrl_pkg::SYNC_A_LEAD: st_d.sync = ra_match && count_down_in;
        stage_ctrl_pkg::SYNC_A_TRAIL: st_d.sync = ra_match && !count_down_in;
        default: st_d.sync = 1'b0;
      endcase
    end else begin
      case (stage_ctrl_pkg::sync_sel_e'(st_q.cfg[`POS_SYNC_HI:`POS_SYNC_LO]))
        stage_ctrl_pkg::SYNC_A_LEAD: st_d.sync = sa_match_in;
        stage_ctrl_pkg::SYNC_A_TRAIL: st_d.sync = ra_match || fault_a_in;
        stage_ctrl_pkg::SYNC_B_LEAD: st_d.sync = sb_match;
        stage_ctrl_pkg::SYNC_B_TRAIL: st_d.sync = rb_match_in || fault_b_in;
        default: st_d.sync = 1'b0;
      endcase
    end
    st_d.lvl[0] = wave_a_in;
    st_d.oe[0] = st_q.cfg[`POS_PART_A_EN];
    st_d.lvl[1] = wave_b_in;
    st_d.oe[1] = st_q.cfg[`POS_PART_B_EN];
    st_d.lvl[2] = st_q.cfg[`POS_OUT2_SEL] ? wave_b_in : wave_a_in;
    st_d.oe[2] = HAS_EXTRA && st_q.cfg[`POS_OUT2_EN];
    st_d.lvl[3] = st_q.cfg[`POS_OUT3_SEL] ? wave_a_in : wave_b_in;
    st_d.oe[3] = HAS_EXTRA && st_q.cfg[`POS_OUT3_EN];
  end
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  always_comb begin
    cfg_out = st_q.cfg;
    cmp_set_a_out = st_q.sa;
    cmp_reset_a_out = st_q.ra;
    cmp_set_b_out = st_q.sb;
    cmp_reset_b_out = st_q.rb;
    adc_sync_out = st_q.sync;
    pin_level_out = st_q.lvl;
    pin_oe_out = st_q.oe;
  end
endmodule : stage_unit

//--- hw/stage_ctrl_output_sync_config.sv
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "stage_ctrl_defines.svh"
module stage_ctrl_output_sync_config (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] centered_in,
  input wire logic [2:0] count_down_in,
  input wire logic [35:0] count_in,
  input wire logic [2:0] wave_a_in,
  input wire logic [2:0] wave_b_in,
  input wire logic [2:0] fault_a_in,
  input wire logic [2:0] fault_b_in,
  input wire logic [2:0] sa_match_in,
  input wire logic [2:0] rb_match_in,
  input wire logic [2:0] retrigger_in,
  input wire logic [2:0] capture_in,
  input wire logic [2:0] sync_error_in,
  output logic [35:0] cmp_set_a_out,
  output logic [35:0] cmp_reset_a_out,
  output logic [35:0] cmp_set_b_out,
  output logic [47:0] cmp_reset_b_out,
  output logic [2:0] adc_sync_out,
  output logic [1:0] wave_out0_out,
  output logic [1:0] wave_out0_oe_out,
  output logic [1:0] wave_out1_out,
  output logic [1:0] wave_out1_oe_out,
  output logic [2:0] wave_out2_out,
  output logic [2:0] wave_out2_oe_out,
  output logic [2:0] wave_out3_out,
  output logic [2:0] wave_out3_oe_out,
  output logic [5:0] irq_req_out,
  output logic [3:0] irq_vector_out,
  output logic [15:0] irq_prog_addr_out,
  output logic irq_out
);
  typedef struct packed {
    stage_ctrl_pkg::bus_state_e bus;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [7:0] temp_high;
    logic [5:0] status;
    logic [5:0] mask;
    logic irq;
    logic [5:0] req;
    logic [3:0] vec;
    logic [15:0] paddr;
  } top_s;
  top_s st_q, st_d;
  logic [2:0] cfg_we, cmp_we;
  logic [2:0] cmp_sel;
  logic [7:0] cfg_rd [3];
  logic [3:0] lvl [3];
  logic [3:0] oe [3];
  logic [5:0] events;
  logic [5:0] pend;
  logic [7:0] w_byte;
  logic do_write;
  always_comb begin
    do_write = st_q.aw_got && st_q.w_got && (st_q.bus == stage_ctrl_pkg::BUS_IDLE);
    w_byte = st_q.wstrb[0] ? st_q.wdata[7:0] : 8'h00;
    cmp_sel = st_q.awaddr[4:2];
  end
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_unit
      always_comb begin
        cfg_we[gi] = do_write && st_q.wstrb[0] &&
          (st_q.awaddr == 8'(`CFG_BASE_ADDR + 4 * gi));
        cmp_we[gi] = do_write && st_q.wstrb[0] &&
          (st_q.awaddr[7:5] == 3'(gi + (`CMP_BASE_ADDR >> 5))) && !cmp_sel[0];
        // bit 0 is end-of-cycle, bit 1 capture
        events[2 * gi] = rb_match_in[gi];
        events[2 * gi + 1] = retrigger_in[gi] || capture_in[gi] || sync_error_in[gi];
      end
      stage_unit #(
        .HAS_EXTRA(gi == 2)
      ) u_unit (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .cfg_we_in(cfg_we[gi]),
        .cfg_wdata_in(w_byte),
        .cmp_we_in(cmp_we[gi]),
        .cmp_sel_in(cmp_sel),
        .temp_high_in(st_q.temp_high),
        .cmp_wdata_in(w_byte),
        .centered_in(centered_in[gi]),
        .count_down_in(count_down_in[gi]),
        .count_in(count_in[12 * gi +: 12]),
        .wave_a_in(wave_a_in[gi]),
        .wave_b_in(wave_b_in[gi]),
        .fault_a_in(fault_a_in[gi]),
        .fault_b_in(fault_b_in[gi]),
        .sa_match_in(sa_match_in[gi]),
        .rb_match_in(rb_match_in[gi]),
        .cfg_out(cfg_rd[gi]),
        .cmp_set_a_out(cmp_set_a_out[12 * gi +: 12]),
        .cmp_reset_a_out(cmp_reset_a_out[12 * gi +: 12]),
        .cmp_set_b_out(cmp_set_b_out[12 * gi +: 12]),
        .cmp_reset_b_out(cmp_reset_b_out[16 * gi +: 16]),
        .adc_sync_out(adc_sync_out[gi]),
        .pin_level_out(lvl[gi]),
        .pin_oe_out(oe[gi])
      );
    end
  endgenerate
  always_comb begin
    wave_out0_out = {lvl[1][0], lvl[0][0]};
    wave_out0_oe_out = {oe[1][0], oe[0][0]};
    wave_out1_out = {lvl[1][1], lvl[0][1]};
    wave_out1_oe_out = {oe[1][1], oe[0][1]};
    wave_out2_out = {lvl[2][0], lvl[2][2], 1'b0};
    wave_out2_oe_out = {oe[2][0], oe[2][2], 1'b0};
    wave_out3_out = {lvl[2][1], lvl[2][3], 1'b0};
    wave_out3_oe_out = {oe[2][1], oe[2][3], 1'b0};
  end
  always_comb begin
    st_d = st_q;
    pend = st_q.status & st_q.mask;
    st_d.req = pend;
    st_d.irq = |pend;
    // instance 2 capture is vector 2, order runs down to instance 0
    st_d.vec = 4'h0;
    st_d.paddr = 16'h0000;
    for (int k = 0; k < 6; k++) begin
      if (pend[5 - k] && st_d.vec == 4'h0) begin
        st_d.vec = 4'(`FIRST_VECTOR + k);
        st_d.paddr = 16'(`FIRST_PROG_ADDR + k);
      end
    end
    if (s_axi_awvalid && !st_q.aw_got) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !st_q.w_got) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    case (st_q.bus)
      stage_ctrl_pkg::BUS_IDLE: begin
        if (do_write) begin
          st_d.aw_got = 1'b0;
          st_d.w_got = 1'b0;
          st_d.resp = 2'b00;
          st_d.bus = stage_ctrl_pkg::BUS_WRESP;
          if (st_q.awaddr[7:5] != 3'h0 && st_q.awaddr[7:5] < 3'h4 && cmp_sel[0]) begin
            st_d.temp_high = w_byte;
          end else if (st_q.awaddr == `IRQ_MASK_ADDR) begin
            st_d.mask = st_q.wdata[5:0];
          end else if (st_q.awaddr == `IRQ_STATUS_ADDR) begin
            st_d.status = st_q.status & ~st_q.wdata[5:0];
          end else if (st_q.awaddr > `VECTOR_ADDR ||
              (st_q.awaddr > `CFG_BASE_ADDR + 8'h08 && st_q.awaddr < `CMP_BASE_ADDR)) begin
            st_d.resp = 2'b10;
          end
        end else if (s_axi_arvalid) begin
          st_d.bus = stage_ctrl_pkg::BUS_RRESP;
          st_d.resp = 2'b00;
          st_d.rdata = 32'h0000_0000;
          case ({s_axi_araddr[7:2], 2'b00})
            `CFG_BASE_ADDR: st_d.rdata = {24'h00_0000, cfg_rd[0]};
            `CFG_BASE_ADDR + 8'h04: st_d.rdata = {24'h00_0000, cfg_rd[1]};
            `CFG_BASE_ADDR + 8'h08: st_d.rdata = {24'h00_0000, cfg_rd[2]};
            `IRQ_STATUS_ADDR: st_d.rdata = {26'h000_0000, st_q.status};
            `IRQ_MASK_ADDR: st_d.rdata = {26'h000_0000, st_q.mask};
            `VECTOR_ADDR: st_d.rdata = {12'h000, st_q.vec, st_q.paddr};
            default: begin
              // compare registers are write only and read as zero
              if (s_axi_araddr[7:5] == 3'h0 || s_axi_araddr[7:5] > 3'h3) begin
                st_d.resp = 2'b10;
              end
            end
          endcase
        end
      end
      stage_ctrl_pkg::BUS_WRESP: begin
        if (s_axi_bready) begin
          st_d.bus = stage_ctrl_pkg::BUS_IDLE;
        end
      end
      stage_ctrl_pkg::BUS_RRESP: begin
        if (s_axi_rready) begin
          st_d.bus = stage_ctrl_pkg::BUS_IDLE;
        end
      end
      default: st_d.bus = stage_ctrl_pkg::BUS_IDLE;
    endcase
    st_d.status = st_d.status | events;
  end
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= '{bus: stage_ctrl_pkg::BUS_IDLE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end
  always_comb begin
    s_axi_awready = !st_q.aw_got;
    s_axi_wready = !st_q.w_got;
    s_axi_bvalid = (st_q.bus == stage_ctrl_pkg::BUS_WRESP);
    s_axi_bresp = st_q.resp;
    s_axi_arready = (st_q.bus == stage_ctrl_pkg::BUS_IDLE) && !do_write;
    s_axi_rvalid = (st_q.bus == stage_ctrl_pkg::BUS_RRESP);
    s_axi_rdata = st_q.rdata;
    s_axi_rresp = st_q.resp;
    irq_req_out = st_q.req;
    irq_vector_out = st_q.vec;
    irq_prog_addr_out = st_q.paddr;
    irq_out = st_q.irq;
  end
endmodule : stage_ctrl_output_sync_config

//--- sim/stage_ctrl_output_sync_config_sva.sv
`timescale 1ns/100ps
module stage_ctrl_sync_checker (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic s_axi_bvalid,
  input wire logic [2:0] wave_a_in,
  input wire logic [2:0] wave_b_in,
  input wire logic [1:0] wave_out0_out,
  input wire logic [1:0] wave_out0_oe_out,
  input wire logic [1:0] wave_out1_out,
  input wire logic [1:0] wave_out1_oe_out,
  input wire logic [2:0] wave_out2_oe_out,
  input wire logic [2:0] wave_out3_oe_out,
  input wire logic [5:0] irq_req_out,
  input wire logic [3:0] irq_vector_out,
  input wire logic [15:0] irq_prog_addr_out,
  input wire logic irq_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  pin_a_level_a: assert property (
    wave_out0_oe_out[0] && $past(wave_out0_oe_out[0]) |-> wave_out0_out[0] == $past(wave_a_in[0]))
    else $error("part a pin level wrong");
  pin_b_level_a: assert property (
    wave_out1_oe_out[0] && $past(wave_out1_oe_out[0]) |-> wave_out1_out[0] == $past(wave_b_in[0]))
    else $error("part b pin level wrong");
  oe_on_write_a: assert property (
    $changed(wave_out0_oe_out) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin enable moved without a write");
  irq_level_a: assert property (
    (|irq_req_out) && $past(|irq_req_out) |-> irq_out)
    else $error("irq low while request pending");
  vec_top_prio_a: assert property (
    irq_req_out[5] && $past(irq_req_out[5]) |-> irq_vector_out == 4'h2)
    else $error("stage 2 capture not first");
  vec_ec_order_a: assert property (
    irq_req_out == 6'h15 && $past(irq_req_out) == 6'h15 |-> irq_vector_out == 4'h3)
    else $error("end cycle vector order wrong");
  vec_addr_map_a: assert property (
    irq_prog_addr_out == (irq_vector_out == 4'h0 ? 16'h0000 : {12'h000, irq_vector_out - 4'h1}))
    else $error("vector address mismatch");
  extra_pin_idle_a: assert property (
    !wave_out2_oe_out[0] && !wave_out3_oe_out[0])
    else $error("unused extra pin enabled");
endmodule : stage_ctrl_sync_checker
bind stage_ctrl_output_sync_config stage_ctrl_sync_checker u_stage_ctrl_sync_checker (.*);

//--- sim/stage_partner.sv
`timescale 1ns/100ps
module stage_partner (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hold_in,
  output logic [35:0] count_out,
  output logic [2:0] down_out,
  output logic [2:0] wave_a_out,
  output logic [2:0] wave_b_out,
  output logic [2:0] sa_match_out,
  output logic [2:0] rb_match_out
);
  logic [3:0] cnt_q;
  logic dir_q;
  // direction flips at each wrap so both centered slopes are seen
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_q <= 1'b0;
    end else if (!hold_in && cnt_q == 4'hF) begin
      dir_q <= !dir_q;
    end
  end
  // parked at 3: a high, b low, no matches
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 4'h3;
    end else if (hold_in) begin
      cnt_q <= 4'h3;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign count_out = {3{8'h00, cnt_q}};
  assign down_out = {3{dir_q}};
  assign wave_a_out = {3{(cnt_q >= 4'h2) && (cnt_q < 4'h6)}};
  assign wave_b_out = {3{(cnt_q >= 4'h8) && (cnt_q < 4'hC)}};
  assign sa_match_out = {3{cnt_q == 4'h2}};
  assign rb_match_out = {3{cnt_q == 4'hC}};
endmodule : stage_partner

//--- sim/tb_stage_ctrl_output_sync_config.sv
`timescale 1ns/100ps
module tb_stage_ctrl_output_sync_config;
  logic core_clk_in, reset_n_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic irq_out, hold;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, wave_out0_out, wave_out0_oe_out;
  logic [1:0] wave_out1_out, wave_out1_oe_out;
  logic [2:0] centered_in, count_down_in, wave_a_in, wave_b_in, fault_a_in, fault_b_in;
  logic [2:0] sa_match_in, rb_match_in, retrigger_in, capture_in, sync_error_in, adc_sync_out;
  logic [2:0] wave_out2_out, wave_out2_oe_out, wave_out3_out, wave_out3_oe_out;
  logic [3:0] s_axi_wstrb, irq_vector_out;
  logic [5:0] irq_req_out;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] irq_prog_addr_out;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [35:0] count_in, cmp_set_a_out, cmp_reset_a_out, cmp_set_b_out;
  logic [47:0] cmp_reset_b_out;
  int err_count = 0;
  int n_compared = 0;
  stage_ctrl_output_sync_config u_stage_ctrl_output_sync_config (.*);
  stage_partner u_stage_partner (.clk_in(core_clk_in), .rst_n_in(reset_n_in), .hold_in(hold),
    .count_out(count_in), .down_out(count_down_in), .wave_a_out(wave_a_in),
    .wave_b_out(wave_b_in), .sa_match_out(sa_match_in), .rb_match_out(rb_match_in));
  always #25 core_clk_in = ~core_clk_in;
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task tmo(input int t);
    if (t == 50) begin
      err_count++;
      results();
    end
  endtask : tmo
  task tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : tick
  task wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge core_clk_in);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    tmo(t);
  endtask : wr
  task rd(input logic [7:0] a);
    int t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge core_clk_in);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_v = s_axi_rdata;
    rs = s_axi_rresp;
    tmo(t);
  endtask : rd
  task t_regs;
    rd(8'h00);
    chk("cfg0", rd_v, 32'h0);
    rd(8'h08);
    chk("cfg2", rd_v, 32'h0);
    wr(8'h04, 32'hCA);
    rd(8'h04);
    chk("spare", {rd_v, wave_out0_oe_out, wave_out1_oe_out}, {32'hCA, 4'h0});
    rd(8'h24);
    chk("wo_read", rd_v, 32'h0);
    rd(8'h0C);
    chk("unmapped", rs, 2'h2);
  endtask : t_regs
  task t_cmp;
    wr(8'h24, 32'hFF);
    chk("sa_held", cmp_set_a_out, 36'h0);
    wr(8'h20, 32'hFF);
    chk("sa", cmp_set_a_out, 36'hFFF);
    wr(8'h2C, 32'h00);
    wr(8'h28, 32'h06);
    wr(8'h34, 32'h00);
    wr(8'h30, 32'h08);
    chk("ra_sb", {cmp_reset_a_out[11:0], cmp_set_b_out[11:0]}, 24'h006008);
    wr(8'h3C, 32'hA5);
    chk("rb_held", cmp_reset_b_out, 48'h0);
    wr(8'h38, 32'hC3);
    chk("rb", cmp_reset_b_out, 48'hA5C3);
  endtask : t_cmp
  task t_pins;
    wr(8'h00, 32'h05);
    wr(8'h08, 32'h0F);
    tick(3);
    chk("oe01", {wave_out0_oe_out, wave_out1_oe_out}, 4'h5);
    chk("lvl01", {wave_out0_out[0], wave_out1_out[0]}, 2'h2);
    chk("oe23", {wave_out2_oe_out, wave_out3_oe_out}, 6'h36);
    chk("sel_clr", {wave_out2_out[2:1], wave_out3_out[2:1]}, 4'hC);
    wr(8'h08, 32'hCF);
    tick(3);
    chk("sel_set", {wave_out2_out[2:1], wave_out3_out[2:1]}, 4'h9);
    wr(8'h08, 32'h00);
    wr(8'h00, 32'h01);
    tick(3);
    chk("oe_off", {wave_out0_oe_out, wave_out1_oe_out, wave_out2_oe_out, wave_out3_oe_out},
      10'h100);
  endtask : t_pins
  task t_sync;
    int s;
    int c;
    hold <= 1'b0;
    for (s = 0; s < 8; s++) begin
      centered_in <= {2'b00, s[2]};
      wr(8'h00, {26'h0, s[1:0], 4'h0});
      tick(4);
      c = 0;
      repeat (32) begin
        @(posedge core_clk_in);
        if (adc_sync_out[0] === 1'b1) c++;
      end
      chk("sync", c, (s < 4) ? 2 : ((s == 4 || s == 5) ? 1 : 0));
    end
    hold <= 1'b1;
    centered_in <= 3'h0;
  endtask : t_sync
  task t_irq;
    wr(8'h80, 32'h3F);
    wr(8'h84, 32'h3F);
    hold <= 1'b0;
    tick(16);
    hold <= 1'b1;
    tick(3);
    chk("ec", {irq_req_out, irq_vector_out, irq_prog_addr_out, irq_out},
      {6'h15, 4'h3, 16'h0002, 1'b1});
    retrigger_in <= 3'h1;
    capture_in <= 3'h2;
    sync_error_in <= 3'h4;
    tick(1);
    {retrigger_in, capture_in, sync_error_in} <= 9'h000;
    tick(3);
    chk("capture_irq", {irq_req_out, irq_vector_out, irq_prog_addr_out}, {6'h3F, 4'h2, 16'h1});
    wr(8'h84, 32'h00);
    tick(3);
    chk("masked", {irq_req_out, irq_out}, 7'h00);
    rd(8'h80);
    chk("status", rd_v, 32'h3F);
    wr(8'h80, 32'h2A);
    rd(8'h80);
    chk("w1c", rd_v, 32'h15);
    wr(8'h80, 32'h15);
    wr(8'h84, 32'h3F);
    tick(3);
    chk("clear", {irq_req_out, irq_vector_out, irq_out}, 11'h000);
  endtask : t_irq
  initial begin
    core_clk_in = 1'b0;
    reset_n_in = 1'b0;
    hold = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {centered_in, fault_a_in, fault_b_in, retrigger_in, capture_in, sync_error_in} = 18'h0;
    s_axi_wstrb = 4'hF;
    tick(20);
    reset_n_in <= 1'b1;
    tick(1);
    t_regs();
    t_cmp();
    t_pins();
    t_sync();
    t_irq();
    results();
  end
endmodule : tb_stage_ctrl_output_sync_config
